// File: rtl/txd_defs.svh
// constants for the transmit descriptor list dma engine
// assumes byte addressed shared memory with 32-bit words
`ifndef TXD_DEFS_SVH
`define TXD_DEFS_SVH
// channel config block word offsets (bytes)
`define TXD_CFG_LIST 32'h0000_0000
`define TXD_CFG_CUR 32'h0000_0008
// descriptor layout
`define TXD_DESC_WORDS 2'h3
`define TXD_CFG_WORDS 2'h2
`define TXD_ONE_WORD 2'h1
`define TXD_EOL_BIT 31
`define TXD_LEN_MSB 15
`define TXD_DW_BYTES 32'h0000_0004
`define TXD_DW_ROUND 17'h0_0003
// interrupt vector tag for transmit completions
`define TXD_VEC_TAG 8'ha0
`endif

// File: rtl/txd_dma.sv
// transmit descriptor list dma engine and its data fifo
// assumes a bus adapter that takes one request at a time and returns
// read words with i_mem_rvalid no earlier than one cycle after i_mem_ack
`timescale 1ns/1ns
`include "txd_defs.svh"

// --------------------------------------------------------------
// data fifo
// --------------------------------------------------------------
module txd_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];  // flop storage
  logic [AW-1:0] wr_idx;
  logic [AW-1:0] rd_idx;
  logic [AW:0] count;  // one bit wider so full is honest
  logic push;
  logic pop;
  assign o_in_ready = (count != (AW+1)'(DEPTH));
  assign o_out_valid = (count != '0);
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;
  assign o_out_data = mem[rd_idx];
  // storage write, indexed by the write pointer
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_idx] <= i_in_data;
    end
  end
  // pointers and occupancy
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      wr_idx <= '0;
      rd_idx <= '0;
      count <= '0;
    end else begin
      if (push) wr_idx <= (wr_idx == AW'(DEPTH-1)) ? '0 : wr_idx + 1'b1;
      if (pop) rd_idx <= (rd_idx == AW'(DEPTH-1)) ? '0 : rd_idx + 1'b1;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

module txd_dma #(
  parameter int FIFO_DEPTH = 16,
  parameter int INTQ_DEPTH = 16
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_host_mode_select,  // bus mode strap, no effect on reset
  input wire logic i_cfg_req,  // pulse: fetch config block and start
  input wire logic i_resume,  // pulse: software appended descriptors
  input wire logic [31:0] i_cfg_base,
  input wire logic [4:0] i_channel,
  output txd_pkg::txd_mem_req_t o_mem,
  output logic o_mem_req,
  input wire logic i_mem_ack,
  input wire logic i_mem_rvalid,
  input wire logic [31:0] i_mem_rdata,
  output logic o_tx_valid,
  output logic [31:0] o_tx_data,
  input wire logic i_tx_ready,
  output logic o_held
);
  import txd_pkg::*;
  localparam int QW = $clog2(INTQ_DEPTH);

  // --------------------------------------------------------------
  // reset: asserted asynchronously, released on a clock edge
  // --------------------------------------------------------------
  logic rst_meta;  // first stage, read only by rst
  logic rst;
  // the mode strap stays out of this path on purpose
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      rst_meta <= 1'b1;
      rst <= 1'b1;
    end else begin
      rst_meta <= 1'b0;
      rst <= rst_meta;
    end
  end

  // --------------------------------------------------------------
  // state and captured descriptor fields
  // --------------------------------------------------------------
  txd_state_t state;
  logic [31:0] desc_addr;  // descriptor being processed
  logic [31:0] next_ptr;  // link word
  logic [31:0] data_ptr;  // next data word address
  logic [31:0] intq_base;  // transmit interrupt queue base
  logic [QW-1:0] intq_idx;  // next queue slot
  logic eol;  // end of list mark of current descriptor
  logic [`TXD_LEN_MSB:0] pkt_len;  // packet length in bytes
  logic [14:0] dcnt;  // data words still to read
  logic [1:0] rcnt;  // words received in this read
  logic busy;  // read taken, words still due
  logic last_word;
  logic need_bus;
  logic fifo_in_ready;
  logic [16:0] len_round;
  logic [1:0] want_words;
  txd_mem_req_t next_mem;

  assign len_round = {1'b0, pkt_len} + `TXD_DW_ROUND;
  assign want_words = (state == TXD_CFG) ? `TXD_CFG_WORDS :
                      (state == TXD_DESC) ? `TXD_DESC_WORDS : `TXD_ONE_WORD;
  assign last_word = i_mem_rvalid && (rcnt == want_words - 2'h1);
  assign o_held = (state == TXD_HOLD);

  // what the current state asks of the bus; data waits for fifo room
  always_comb begin
    next_mem = '0;
    next_mem.words = want_words;
    need_bus = 1'b1;
    case (state)
      TXD_CFG: next_mem.addr = i_cfg_base + `TXD_CFG_LIST;
      TXD_DESC: next_mem.addr = desc_addr;
      TXD_DATA: begin
        next_mem.addr = data_ptr;
        need_bus = fifo_in_ready && (dcnt != '0);
      end
      TXD_VEC: begin
        next_mem.we = 1'b1;
        next_mem.addr = intq_base + {{(30-QW){1'b0}}, intq_idx, 2'b00};
        next_mem.wdata = {`TXD_VEC_TAG, 3'h0, i_channel, pkt_len};
      end
      TXD_CUR: begin
        next_mem.we = 1'b1;
        next_mem.addr = i_cfg_base + `TXD_CFG_CUR;
        next_mem.wdata = eol ? desc_addr : next_ptr;
      end
      TXD_RELINK: next_mem.addr = desc_addr + `TXD_DW_BYTES;
      default: need_bus = 1'b0;
    endcase
  end

  // --------------------------------------------------------------
  // bus request: one transaction outstanding at a time
  // --------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (rst) begin
      o_mem_req <= 1'b0;
      o_mem <= '0;
      busy <= 1'b0;
      rcnt <= '0;
    end else begin
      if (!o_mem_req && !busy && need_bus) begin
        o_mem_req <= 1'b1;
        o_mem <= next_mem;
      end else if (o_mem_req && i_mem_ack) begin
        o_mem_req <= 1'b0;
        busy <= !o_mem.we;  // writes end at the ack
      end
      if (last_word) begin
        busy <= 1'b0;
        rcnt <= '0;
      end else if (i_mem_rvalid) begin
        rcnt <= rcnt + 2'h1;
      end
    end
  end

  // --------------------------------------------------------------
  // list walk
  // --------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (rst) begin
      state <= TXD_IDLE;
      desc_addr <= '0;
      next_ptr <= '0;
      data_ptr <= '0;
      intq_base <= '0;
      intq_idx <= '0;
      eol <= 1'b0;
      pkt_len <= '0;
      dcnt <= '0;
    end else begin
      case (state)
        TXD_IDLE: if (i_cfg_req) state <= TXD_CFG;
        TXD_CFG: if (i_mem_rvalid) begin
          if (rcnt == 2'h0) desc_addr <= i_mem_rdata;
          else intq_base <= i_mem_rdata;
          if (last_word) state <= TXD_DESC;
        end
        TXD_DESC: if (i_mem_rvalid) begin
          case (rcnt)
            2'h0: begin
              eol <= i_mem_rdata[`TXD_EOL_BIT];
              pkt_len <= i_mem_rdata[`TXD_LEN_MSB:0];
            end
            2'h1: next_ptr <= i_mem_rdata;
            default: begin
              data_ptr <= i_mem_rdata;
              dcnt <= len_round[16:2];
            end
          endcase
          if (last_word) state <= TXD_DATA;
        end
        TXD_DATA: begin
          if (dcnt == '0) begin
            state <= TXD_VEC;
          end else if (i_mem_rvalid) begin
            data_ptr <= data_ptr + `TXD_DW_BYTES;
            dcnt <= dcnt - 15'h1;
          end
        end
        TXD_VEC: if (o_mem_req && i_mem_ack) begin
          intq_idx <= (intq_idx == QW'(INTQ_DEPTH-1)) ? '0 : intq_idx + 1'b1;
          state <= TXD_CUR;
        end
        TXD_CUR: if (o_mem_req && i_mem_ack) begin
          if (eol) begin
            state <= TXD_HOLD;
          end else begin
            desc_addr <= next_ptr;
            state <= TXD_DESC;
          end
        end
        TXD_HOLD: begin
          if (i_cfg_req) state <= TXD_CFG;
          else if (i_resume) state <= TXD_RELINK;
        end
        TXD_RELINK: if (i_mem_rvalid) begin  // re-read link of held descriptor
          desc_addr <= i_mem_rdata;
          state <= TXD_DESC;
        end
        default: state <= TXD_IDLE;
      endcase
    end
  end

  // --------------------------------------------------------------
  // data fifo: fetched words wait here for the serial side
  // --------------------------------------------------------------
  txd_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_clk(i_clk),
    .i_reset(rst),
    .i_in_valid(state == TXD_DATA && i_mem_rvalid),
    .o_in_ready(fifo_in_ready),
    .i_in_data(i_mem_rdata),
    .o_out_valid(o_tx_valid),
    .i_out_ready(i_tx_ready),
    .o_out_data(o_tx_data)
  );

  // --------------------------------------------------------------
  // checks
  // --------------------------------------------------------------
  chk_desc_burst: assert property (@(posedge i_clk) disable iff (rst)
    o_mem_req && state == TXD_DESC |-> o_mem.words == 2'h3 && !o_mem.we && o_mem.addr == desc_addr)
    else $error("descriptor read is not a three word burst");
  chk_data_single: assert property (@(posedge i_clk) disable iff (rst)
    o_mem_req && state == TXD_DATA |-> o_mem.words == 2'h1 && !o_mem.we && o_mem.addr == data_ptr)
    else $error("data read not single word at data pointer");
  chk_data_room: assert property (@(posedge i_clk) disable iff (rst)
    $rose(o_mem_req) && state == TXD_DATA |-> $past(fifo_in_ready) && $past(dcnt) != '0)
    else $error("data read issued without fifo room");
  chk_vector_write: assert property (@(posedge i_clk) disable iff (rst)
    o_mem_req && state == TXD_VEC |-> o_mem.we && o_mem.wdata[15:0] == pkt_len
      && o_mem.addr == intq_base + {{(30-QW){1'b0}}, intq_idx, 2'b00})
    else $error("vector write malformed");
  chk_cur_write: assert property (@(posedge i_clk) disable iff (rst)
    o_mem_req && state == TXD_CUR |-> o_mem.we && o_mem.addr == i_cfg_base + `TXD_CFG_CUR)
    else $error("current address write misplaced");
  chk_link_follow: assert property (@(posedge i_clk) disable iff (rst)
    state == TXD_CUR && o_mem_req && i_mem_ack && !eol |=> state == TXD_DESC && desc_addr == $past(next_ptr))
    else $error("link not followed after update");
  chk_hold_quiet: assert property (@(posedge i_clk) disable iff (rst)
    state == TXD_HOLD && !i_resume && !i_cfg_req |=> state == TXD_HOLD && !o_mem_req ##1 !o_mem_req)
    else $error("engine left hold without resume");
  chk_cfg_on_req: assert property (@(posedge i_clk) disable iff (rst)
    state == TXD_IDLE && !i_cfg_req |=> state == TXD_IDLE && !o_mem_req)
    else $error("config block fetched without request");
  chk_reset_async: assert property (@(posedge i_clk)
    i_reset |=> rst && state == TXD_IDLE ##1 !o_mem_req)
    else $error("reset not taken");
  cov_hold: cover property (@(posedge i_clk) disable iff (rst) state == TXD_CUR ##1 state == TXD_HOLD);
  cov_resume: cover property (@(posedge i_clk) disable iff (rst) state == TXD_HOLD ##1 state == TXD_RELINK);
  cov_fifo_full: cover property (@(posedge i_clk) disable iff (rst) state == TXD_DATA && !fifo_in_ready);
endmodule

// File: rtl/txd_pkg.sv
// types shared by the transmit descriptor list dma engine
// assumes txd_defs.svh supplies the numeric constants
package txd_pkg;
  // gray coded states along fetch, data, vector, pointer update
  typedef enum logic [2:0] {
    TXD_IDLE = 3'h0,
    TXD_CFG = 3'h1,
    TXD_DESC = 3'h3,
    TXD_DATA = 3'h2,
    TXD_VEC = 3'h6,
    TXD_CUR = 3'h7,
    TXD_HOLD = 3'h5,
    TXD_RELINK = 3'h4
  } txd_state_t;
  // one memory transaction as seen by the system bus adapter
  typedef struct packed {
    logic we;
    logic [1:0] words;
    logic [31:0] addr;
    logic [31:0] wdata;
  } txd_mem_req_t;
endpackage

// File: verification/tb_tx_descriptor_list_dma.sv
// self-checking bench for the transmit descriptor dma engine
// assumes txd_host_mem stands in for host memory
`timescale 1ns/1ns

module tb_tx_descriptor_list_dma;
  import txd_pkg::*;
  localparam logic [31:0] CFG_BASE = 32'h100;
  localparam logic [31:0] INTQ = 32'h400;
  logic i_clk, i_reset, i_mode, i_cfg, i_resume, i_ready, slow, stall;
  logic o_req, ack, rv, o_txv, o_held;
  logic [4:0] ch;
  logic [31:0] rd, o_txd;
  txd_mem_req_t o_mem, e;
  txd_mem_req_t exp_q[$];  // expected memory traffic
  logic [31:0] tx_q[$];  // expected stream words
  int fails, n_tests, idx, rd_cnt, pass, t;

  txd_dma dut_u (.i_clk(i_clk), .i_reset(i_reset), .i_host_mode_select(i_mode), .i_cfg_req(i_cfg),
    .i_resume(i_resume), .i_cfg_base(CFG_BASE), .i_channel(ch), .o_mem(o_mem), .o_mem_req(o_req),
    .i_mem_ack(ack), .i_mem_rvalid(rv), .i_mem_rdata(rd), .o_tx_valid(o_txv), .o_tx_data(o_txd),
    .i_tx_ready(i_ready), .o_held(o_held));
  txd_host_mem host_u (.i_clk(i_clk), .i_reset(i_reset), .i_slow(slow), .i_mem(o_mem),
    .i_mem_req(o_req), .o_mem_ack(ack), .o_mem_rvalid(rv), .o_mem_rdata(rd));

  // ----------------------------------------
  // reporting
  // ----------------------------------------
  task chk(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'b1) begin
      fails++;
      $display("wrong value at %0t: %s", $time, msg);
    end
  endtask
  task finish_test;
    $display("checks %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // reference model: memory image and expected traffic
  // ----------------------------------------
  task push(input logic we, input logic [1:0] w, input logic [31:0] a, input logic [31:0] d);
    exp_q.push_back('{we: we, words: w, addr: a, wdata: d});
  endtask
  // one descriptor: burst, data words, vector, current address
  task desc(input logic [31:0] a, input logic eol, input logic [15:0] len, input logic [31:0] nxt,
    input logic [31:0] p);
    int k;
    logic [31:0] d;
    host_u.mem[a] = {eol, 15'h0, len};
    host_u.mem[a + 32'h4] = nxt;
    host_u.mem[a + 32'h8] = p;
    push(1'b0, 2'h3, a, 32'h0);
    for (k = 0; k < (int'(len) + 3) / 4; k++) begin
      d = $urandom;
      host_u.mem[p + 4 * k] = d;
      tx_q.push_back(d);
      push(1'b0, 2'h1, p + 4 * k, 32'h0);
    end
    push(1'b1, 2'h1, INTQ + 4 * idx, {8'ha0, 3'h0, ch, len});
    idx = (idx + 1) % 16;
    push(1'b1, 2'h1, CFG_BASE + 32'h8, eol ? a : nxt);
  endtask

  // ----------------------------------------
  // stimulus helpers
  // ----------------------------------------
  task pulse(input logic c, input logic r);
    i_cfg <= c;
    i_resume <= r;
    @(posedge i_clk);
    i_cfg <= 1'b0;
    i_resume <= 1'b0;
    @(posedge i_clk);
  endtask
  // bounded wait for the list walk to drain into the hold state
  task wait_done;
    t = 0;
    while ((exp_q.size() > 0 || tx_q.size() > 0 || o_held !== 1'b1) && t < 20000) begin
      @(posedge i_clk);
      t++;
    end
    if (t >= 20000) begin
      fails++;
      $display("wrong value at %0t: walk timed out", $time);
      finish_test();
    end
  endtask

  // ----------------------------------------
  // clock, sink and monitors
  // ----------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  // sink accepts at random, or stalls to fill the fifo
  always @(posedge i_clk) i_ready <= !stall && ($urandom_range(3, 0) != 0);
  always @(posedge i_clk) begin
    if (i_reset === 1'b0 && o_req === 1'b1 && ack === 1'b1) begin
      if (stall === 1'b1 && o_mem.we === 1'b0 && o_mem.words === 2'h1) rd_cnt++;
      if (exp_q.size() == 0) begin
        chk(1'b0, "request past list end");
      end else begin
        e = exp_q.pop_front();
        chk(o_mem.we === e.we && o_mem.addr === e.addr && (e.we ? o_mem.wdata === e.wdata : o_mem.words === e.words), "memory request");
      end
    end
    if (i_reset === 1'b0 && o_txv === 1'b1 && i_ready === 1'b1) begin
      if (tx_q.size() == 0) chk(1'b0, "extra stream word");
      else chk(o_txd === tx_q.pop_front(), "stream word");
    end
  end

  // ----------------------------------------
  // main sequence: one pass per host bus mode
  // ----------------------------------------
  initial begin
    {i_reset, i_mode, i_cfg, i_resume, slow, stall, ch} = {1'b1, 10'h0};
    fails = 0;
    n_tests = 0;
    rd_cnt = 0;
    void'($urandom(32'h4afd));
    for (pass = 0; pass < 2; pass++) begin
      @(posedge i_clk);
      i_reset <= 1'b1;
      i_mode <= pass[0];
      slow <= pass[0];
      ch <= 5'($urandom);
      repeat (10) @(posedge i_clk);
      chk(o_req === 1'b0 && o_txv === 1'b0 && o_held === 1'b0, "outputs in reset");
      i_reset <= 1'b0;
      idx = 0;
      rd_cnt = 0;
      repeat (3) @(posedge i_clk);
      host_u.mem[CFG_BASE] = 32'h200;
      host_u.mem[CFG_BASE + 32'h4] = INTQ;
      push(1'b0, 2'h2, CFG_BASE, 32'h0);
      desc(32'h200, 1'b0, 16'h0, 32'h240, 32'h1000);
      desc(32'h240, 1'b0, 16'h5, 32'h280, 32'h1100);
      desc(32'h280, 1'b0, 16'h50, 32'h2c0, 32'h1200);
      desc(32'h2c0, 1'b1, 16'h3, 32'h0, 32'h1300);
      stall <= 1'b1;
      pulse(1'b1, 1'b0);
      repeat (300) @(posedge i_clk);
      chk(rd_cnt === 16 && o_txv === 1'b1, "fifo fill under stall");
      pulse(1'b1, 1'b1);
      stall <= 1'b0;
      wait_done();
      repeat (20) @(posedge i_clk);
      chk(o_held === 1'b1, "held at list end");
      host_u.mem[32'h2c4] = 32'h300;
      push(1'b0, 2'h1, 32'h2c4, 32'h0);
      desc(32'h300, 1'b1, 16'h8, 32'h0, 32'h1400);
      pulse(1'b0, 1'b1);
      wait_done();
      // a fresh config request while held refetches the block and restarts
      host_u.mem[CFG_BASE] = 32'h300;
      push(1'b0, 2'h2, CFG_BASE, 32'h0);
      desc(32'h300, 1'b1, 16'h9, 32'h0, 32'h1500);
      pulse(1'b1, 1'b0);
      wait_done();
      $display("pass %0d done", pass);
    end
    finish_test();
  end
endmodule

// File: verification/txd_host_mem.sv
// host side shared memory model for the transmit dma engine
// assumes one request at a time, held until acknowledged
`timescale 1ns/1ns

// ----------------------------------------
// host memory with slow and prompt answers
// ----------------------------------------
module txd_host_mem (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_slow,  // adds random wait states
  input wire txd_pkg::txd_mem_req_t i_mem,
  input wire logic i_mem_req,
  output logic o_mem_ack,
  output logic o_mem_rvalid,
  output logic [31:0] o_mem_rdata
);
  import txd_pkg::*;
  logic [31:0] mem [logic [31:0]];  // lists, queues and config block
  txd_mem_req_t req;
  logic [31:0] d;
  int k;
  int g;
  initial begin
    o_mem_ack = 1'b0;
    o_mem_rvalid = 1'b0;
    o_mem_rdata = 32'h0;
    d = 32'h0;
  end
  // serve each request; software never touches engine registers here
  always begin
    @(posedge i_clk);
    if (i_reset === 1'b0 && i_mem_req === 1'b1) begin
      repeat ($urandom_range(i_slow ? 3 : 0, 0)) @(posedge i_clk);
      req = i_mem;
      o_mem_ack <= 1'b1;
      @(posedge i_clk);
      o_mem_ack <= 1'b0;
      if (req.we) begin
        mem[req.addr] = req.wdata;
      end else begin
        for (k = 0; k < int'(req.words); k++) begin
          g = $urandom_range(i_slow ? 2 : 0, 0);
          // released data bus shows the inverse, not a stale word
          if (g > 0) begin
            o_mem_rvalid <= 1'b0;
            o_mem_rdata <= ~d;
            repeat (g) @(posedge i_clk);
          end
          d = mem.exists(req.addr + 4 * k) ? mem[req.addr + 4 * k] : 32'h0;
          o_mem_rvalid <= 1'b1;
          o_mem_rdata <= d;
          @(posedge i_clk);
        end
        o_mem_rvalid <= 1'b0;
        o_mem_rdata <= ~d;
      end
    end
  end
endmodule
